// ===== inc/async_tx_cfg.svh
// constants for the asynchronous serial transmitter
`ifndef ASYNC_TX_CFG_SVH
`define ASYNC_TX_CFG_SVH

// register offsets
`define TX_STATUS_CONTROL_OFS 4'h0
`define RX_STATUS_CONTROL_OFS 4'h1
`define BAUD_CONTROL_OFS 4'h2
`define BAUD_LOW_OFS 4'h3
`define BAUD_HIGH_OFS 4'h4
`define TRANSMIT_BUFFER_OFS 4'h5
`define PERIPH_FLAG_ONE_OFS 4'h6
`define PERIPH_IRQ_EN_ONE_OFS 4'h7

// field positions
`define TSC_TX_ENABLE 0
`define TSC_CLOCKED_MODE 1
`define TSC_NINE_BIT 2
`define TSC_NINTH_DATA 3
`define TSC_EMPTY 4
`define TSC_BUSY 5
`define RSC_PORT_ON 7
`define BC_POLARITY 0
`define BC_WIDE 1
`define PF_EMPTY 0
`define PIE_EMPTY 0

// reset values and data bit counts
`define BAUD_LOW_RST 8'h00
`define BAUD_HIGH_RST 8'h00
`define DATA_BITS_SHORT 4'h8
`define DATA_BITS_LONG 4'h9

`endif

// ===== inc/async_tx_pkg.sv
// types for the asynchronous serial transmitter
package async_tx_pkg;

  // gray order along idle -> start -> data -> stop
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b11,
    TX_STOP = 2'b10
  } tx_fsm_t;

  typedef logic [7:0] byte_t;

endpackage

// ===== rtl/async_serial_transmitter.sv
// asynchronous serial transmitter with register port
`include "async_tx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module async_serial_transmitter #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire async_tx_pkg::byte_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // serial line
  output logic serial_out_clock_pin,
  output logic serial_out_clock_pin_oe_n,
  // interrupt request
  output logic tx_irq_req
);
  import async_tx_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    tx_fsm_t fsm;
    logic tx_enable;
    logic clocked_mode;
    logic nine_bit;
    logic ninth_data;
    logic serial_port_on;
    logic line_polarity_select;
    logic wide_baud;
    logic tx_empty_irq_enable;
    logic [7:0] baud_low;
    logic [7:0] baud_high;
    logic [8:0] transmit_buffer_reg;
    logic buf_full;
    logic [8:0] transmit_shift_reg;
    logic [3:0] bit_cnt;
    logic frame_nine;
    logic [15:0] baud_cnt;
    logic line;
    logic oe_n;
    logic tx_buffer_empty_flag;
    logic irq;
    logic [7:0] rd_data;
  } state_t;

  localparam state_t STATE_RST = '{
    fsm: TX_IDLE,
    tx_enable: 1'b0,
    clocked_mode: 1'b0,
    nine_bit: 1'b0,
    ninth_data: 1'b0,
    serial_port_on: 1'b0,
    line_polarity_select: 1'b0,
    wide_baud: 1'b0,
    tx_empty_irq_enable: 1'b0,
    baud_low: `BAUD_LOW_RST,
    baud_high: `BAUD_HIGH_RST,
    transmit_buffer_reg: 9'h000,
    buf_full: 1'b0,
    transmit_shift_reg: 9'h000,
    bit_cnt: 4'h0,
    frame_nine: 1'b0,
    baud_cnt: 16'h0000,
    line: 1'b1,
    oe_n: 1'b1,
    tx_buffer_empty_flag: 1'b0,
    irq: 1'b0,
    rd_data: 8'h00
  };

  state_t s;
  state_t next_s;

  logic active;
  logic tick;
  logic [15:0] divisor;
  logic level;
  logic buf_write;
  logic queued;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_ofs(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    is_ofs = (a == ADDR_W'(ofs));
  endfunction

  function automatic logic [7:0] read_mux(input state_t st, input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (is_ofs(a, `TX_STATUS_CONTROL_OFS))
    begin
      v[`TSC_TX_ENABLE] = st.tx_enable;
      v[`TSC_CLOCKED_MODE] = st.clocked_mode;
      v[`TSC_NINE_BIT] = st.nine_bit;
      v[`TSC_NINTH_DATA] = st.ninth_data;
      v[`TSC_EMPTY] = st.tx_buffer_empty_flag;
      v[`TSC_BUSY] = (st.fsm != TX_IDLE);
    end
    else if (is_ofs(a, `RX_STATUS_CONTROL_OFS))
      v[`RSC_PORT_ON] = st.serial_port_on;
    else if (is_ofs(a, `BAUD_CONTROL_OFS))
    begin
      v[`BC_POLARITY] = st.line_polarity_select;
      v[`BC_WIDE] = st.wide_baud;
    end
    else if (is_ofs(a, `BAUD_LOW_OFS))
      v = st.baud_low;
    else if (is_ofs(a, `BAUD_HIGH_OFS))
      v = st.baud_high;
    else if (is_ofs(a, `PERIPH_FLAG_ONE_OFS))
      v[`PF_EMPTY] = st.tx_buffer_empty_flag;
    else if (is_ofs(a, `PERIPH_IRQ_EN_ONE_OFS))
      v[`PIE_EMPTY] = st.tx_empty_irq_enable;
    read_mux = v;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    active = s.tx_enable & ~s.clocked_mode & s.serial_port_on;
    divisor = s.wide_baud ? {s.baud_high, s.baud_low} : {8'h00, s.baud_low};
    tick = (s.baud_cnt == 16'h0000);
    buf_write = wr_en & is_ofs(addr, `TRANSMIT_BUFFER_OFS);
    // a character beside an idle shifter moves on at the next edge, so only
    // a queue behind a busy shifter counts against the empty flag
    queued = s.buf_full & (s.fsm != TX_IDLE);

    // software-writable control; flag registers are not writable
    if (wr_en)
    begin
      if (is_ofs(addr, `TX_STATUS_CONTROL_OFS))
      begin
        next_s.tx_enable = wr_data[`TSC_TX_ENABLE];
        next_s.clocked_mode = wr_data[`TSC_CLOCKED_MODE];
        next_s.nine_bit = wr_data[`TSC_NINE_BIT];
        next_s.ninth_data = wr_data[`TSC_NINTH_DATA];
      end
      if (is_ofs(addr, `RX_STATUS_CONTROL_OFS))
        next_s.serial_port_on = wr_data[`RSC_PORT_ON];
      if (is_ofs(addr, `BAUD_CONTROL_OFS))
      begin
        next_s.line_polarity_select = wr_data[`BC_POLARITY];
        next_s.wide_baud = wr_data[`BC_WIDE];
      end
      if (is_ofs(addr, `BAUD_LOW_OFS))
        next_s.baud_low = wr_data;
      if (is_ofs(addr, `BAUD_HIGH_OFS))
        next_s.baud_high = wr_data;
      if (is_ofs(addr, `PERIPH_IRQ_EN_ONE_OFS))
        next_s.tx_empty_irq_enable = wr_data[`PIE_EMPTY];
    end

    // baud generator: one bit is divisor+1 cycles
    next_s.baud_cnt = tick ? divisor : s.baud_cnt - 16'h0001;

    unique case (s.fsm)
      TX_IDLE:
      begin
        if (s.buf_full)
        begin
          // the shift register is only ever fed from the buffer
          next_s.transmit_shift_reg = s.transmit_buffer_reg;
          next_s.buf_full = 1'b0;
          next_s.frame_nine = s.nine_bit;
          next_s.baud_cnt = divisor;
          next_s.fsm = TX_START;
        end
      end
      TX_START:
      begin
        if (tick)
        begin
          next_s.bit_cnt = 4'h0;
          next_s.fsm = TX_DATA;
        end
      end
      TX_DATA:
      begin
        if (tick)
        begin
          next_s.transmit_shift_reg = {1'b0, s.transmit_shift_reg[8:1]};
          next_s.bit_cnt = s.bit_cnt + 4'h1;
          if (s.bit_cnt == (s.frame_nine ? `DATA_BITS_LONG : `DATA_BITS_SHORT) - 4'h1)
            next_s.fsm = TX_STOP;
        end
      end
      TX_STOP:
      begin
        if (tick)
        begin
          // a queued character skips idle: handed over on the same edge
          if (s.buf_full)
          begin
            next_s.transmit_shift_reg = s.transmit_buffer_reg;
            next_s.buf_full = 1'b0;
            next_s.frame_nine = s.nine_bit;
            next_s.baud_cnt = divisor;
            next_s.fsm = TX_START;
          end
          else
            next_s.fsm = TX_IDLE;
        end
      end
    endcase

    // a write in the hand-over cycle is queued behind the loaded one
    if (buf_write && active)
    begin
      next_s.transmit_buffer_reg = {s.ninth_data, wr_data};
      next_s.buf_full = 1'b1;
    end

    // disabling drops the frame and any queued character
    if (!active)
    begin
      next_s.fsm = TX_IDLE;
      next_s.buf_full = 1'b0;
      next_s.bit_cnt = 4'h0;
    end

    unique case (next_s.fsm)
      TX_IDLE: level = 1'b1;
      TX_START: level = 1'b0;
      TX_DATA: level = next_s.transmit_shift_reg[0];
      TX_STOP: level = 1'b1;
    endcase
    // in clocked mode the polarity bit has another meaning
    next_s.line = level ^ (next_s.line_polarity_select & ~next_s.clocked_mode);
    next_s.oe_n = ~next_s.serial_port_on;

    // flag lags the buffer by one extra cycle, so a poll right after
    // a write still sees the old value
    next_s.tx_buffer_empty_flag = active & ~queued;
    next_s.irq = s.tx_buffer_empty_flag & s.tx_empty_irq_enable;
    next_s.rd_data = rd_en ? read_mux(s, addr) : 8'h00;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      s <= STATE_RST;
    else
      s <= next_s;
  end

  assign rd_data = s.rd_data;
  assign serial_out_clock_pin = s.line;
  assign serial_out_clock_pin_oe_n = s.oe_n;
  assign tx_irq_req = s.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic inv;
  assign inv = s.line_polarity_select & ~s.clocked_mode;

  a_idle_mark_level: assert property (
    s.fsm == TX_IDLE |-> serial_out_clock_pin == ~inv)
    else $error("idle line not at mark");

  a_start_stop_level: assert property (
    (s.fsm == TX_START |-> serial_out_clock_pin == inv) and
    (s.fsm == TX_STOP |-> serial_out_clock_pin == ~inv))
    else $error("start or stop bit at wrong level");

  a_bit_level_hold: assert property (
    (active && s.fsm != TX_IDLE && s.baud_cnt != 16'h0000 && !wr_en)
      |=> $stable(serial_out_clock_pin))
    else $error("line moved inside a bit");

  a_lsb_first_out: assert property (
    (active && s.fsm == TX_START && tick && !wr_en)
      |=> serial_out_clock_pin == ($past(s.transmit_shift_reg[0]) ^ inv))
    else $error("first data bit is not the lsb");

  a_data_bit_count: assert property (
    (active && s.fsm == TX_DATA && tick && s.frame_nine && s.bit_cnt == 4'h8)
      |=> s.fsm == TX_STOP)
    else $error("nine-bit frame ended at wrong bit");

  a_queue_handoff: assert property (
    (active && s.fsm == TX_STOP && tick && s.buf_full && !buf_write)
      |=> s.fsm == TX_START && !s.buf_full)
    else $error("queued character not taken after stop");

  a_disable_flush: assert property (
    !active |=> s.fsm == TX_IDLE && !s.buf_full)
    else $error("path not emptied while disabled");

  a_flag_late_clear: assert property (
    (active && buf_write && s.fsm == TX_DATA && !s.buf_full &&
      s.baud_cnt > 16'h0002 && !(wr_en && is_ofs(addr, `TX_STATUS_CONTROL_OFS)))
      |=> s.tx_buffer_empty_flag ##1 !s.tx_buffer_empty_flag)
    else $error("empty flag timing after write wrong");

  a_pin_direction: assert property (
    s.serial_port_on |-> !serial_out_clock_pin_oe_n)
    else $error("pin not an output with port on");

  a_irq_gating: assert property (
    !s.tx_empty_irq_enable |=> !tx_irq_req)
    else $error("interrupt raised while disabled");

  a_idle_load_start: assert property (
    (active && s.fsm == TX_IDLE && s.buf_full)
      |=> s.fsm == TX_START && s.transmit_shift_reg == $past(s.transmit_buffer_reg))
    else $error("idle shifter did not take the buffer");

  a_flag_on_enable: assert property (
    (active && !s.buf_full)
      |=> s.tx_buffer_empty_flag)
    else $error("empty flag not set while enabled and empty");

  a_flag_queue_only: assert property (
    ((s.buf_full && s.fsm != TX_IDLE) |=> !s.tx_buffer_empty_flag) and
    ((active && s.fsm == TX_IDLE) |=> s.tx_buffer_empty_flag))
    else $error("empty flag wrong for queue state");

  a_ninth_bit_load: assert property (
    (active && buf_write)
      |=> s.buf_full && s.transmit_buffer_reg == {$past(s.ninth_data), $past(wr_data)})
    else $error("buffer write did not capture ninth bit and data");

  a_start_then_data: assert property (
    (active && s.fsm == TX_START && tick)
      |=> s.fsm == TX_DATA && s.bit_cnt == 4'h0)
    else $error("start bit not followed by data bits");

  a_eight_bit_count: assert property (
    (active && s.fsm == TX_DATA && tick && !s.frame_nine && s.bit_cnt == 4'h7)
      |=> s.fsm == TX_STOP)
    else $error("eight-bit frame ended at wrong bit");

  a_single_stop_bit: assert property (
    (active && s.fsm == TX_STOP && tick && !s.buf_full)
      |=> s.fsm == TX_IDLE)
    else $error("stop bit did not end the frame");

  a_refuse_inactive: assert property (
    (buf_write && !active)
      |=> $stable(s.transmit_buffer_reg))
    else $error("buffer written while transmitter inactive");

  a_narrow_divider: assert property (
    (tick && !s.wide_baud)
      |=> s.baud_cnt == {8'h00, $past(s.baud_low)})
    else $error("8-bit divider reload wrong");

  a_flag_off_disabled: assert property (
    !active
      |=> !s.tx_buffer_empty_flag)
    else $error("empty flag set while transmitter inactive");

  a_next_data_bit: assert property (
    (active && s.fsm == TX_DATA && tick && !wr_en)
      |=> s.fsm == TX_STOP || serial_out_clock_pin == ($past(s.transmit_shift_reg[1]) ^ inv))
    else $error("data bits not sent in ascending order");

  a_oe_port_off: assert property (
    !s.serial_port_on
      |-> serial_out_clock_pin_oe_n)
    else $error("pin driven while port off");

endmodule

`default_nettype wire

// ===== tb/async_serial_transmitter_test.sv
// self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ns
`default_nettype none
module async_serial_transmitter_test;
  import async_tx_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = '0;
  byte_t wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic line, oe_n, irq, got, stop_ok, pol = 1'b0, nine = 1'b0, ninth = 1'b0;
  logic listen = 1'b1;
  logic [8:0] word;
  logic [7:0] v;
  int gap, fails = 0, n_checks = 0, seed = 64, bits = 4;
  logic [8:0] exp_q[$];
  always #10 core_clk = ~core_clk;
  async_serial_transmitter dut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .serial_out_clock_pin(line), .serial_out_clock_pin_oe_n(oe_n), .tx_irq_req(irq));
  serial_rx_model far (.core_clk(core_clk), .line(line), .pol(pol), .nine(nine),
    .bit_cycles(bits), .got(got), .word(word), .stop_ok(stop_ok), .gap(gap));
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input byte_t d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    get(a, v);
    check({1'b0, v}, {1'b0, exp});
  endtask
  task automatic send(input byte_t d);
    exp_q.push_back({ninth & nine, d});
    wr(4'h5, d);
  endtask
  // waits for the shifter to go idle, bounded
  task automatic drain;
    repeat (3000)
    begin
      get(4'h0, v);
      if (v[5] === 1'b0)
        break;
    end
    repeat (2 * bits) @(posedge core_clk);
    check(9'(exp_q.size()), 9'h0);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge got)
    if (listen && exp_q.size() > 0)
    begin
      check(word, exp_q.pop_front());
      check({8'h0, stop_ok}, 9'h1);
    end
  initial
  begin
    #1200000;
    fails++;
    print_verdict();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 10; a++) rd(4'(a), 8'h00);
    check({7'h0, line, oe_n}, 9'h3);
    wr(4'h1, 8'h80);
    #1 check({7'h0, line, oe_n}, 9'h2);
    wr(4'h0, 8'h03);
    wr(4'h2, 8'h01);
    #1 check({8'h0, line}, 9'h1);
    wr(4'h5, 8'h55);
    rd(4'h0, 8'h03);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h01);
    rd(4'h6, 8'h01);
    wr(4'h3, 8'h03);
    wr(4'h6, 8'h00);
    rd(4'h6, 8'h01);
    wr(4'h7, 8'h01);
    // the request follows the flag one edge after the enable lands
    @(posedge core_clk);
    #1 check({8'h0, irq}, 9'h1);
    for (int k = 0; k < 4; k++)
    begin
      send(8'($random(seed)));
      send(8'($random(seed)));
      @(posedge core_clk);
      rd(4'h6, 8'h00);
      #1 check({8'h0, irq}, 9'h0);
      if (k == 3) wr(4'h7, 8'h00);
      drain();
      check(9'(gap), 9'(10 * bits));
    end
    nine = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      ninth = k[0];
      wr(4'h0, {4'h0, ninth, 3'h5});
      send(8'($random(seed)));
      drain();
    end
    nine = 1'b0;
    wr(4'h0, 8'h01);
    wr(4'h4, 8'h01);
    wr(4'h3, 8'h02);
    wr(4'h2, 8'h02);
    bits = 259;
    send(8'h96);
    // second character lands mid-frame and waits in the buffer
    repeat (600) @(posedge core_clk);
    send(8'h3c);
    rd(4'h6, 8'h00);
    drain();
    check(9'(gap - 10 * bits), 9'h000);
    wr(4'h2, 8'h01);
    // change the model's polarity off the edge so it never sees a false start
    #1 pol = 1'b1;
    wr(4'h4, 8'h00);
    wr(4'h3, 8'h03);
    bits = 4;
    #1 check({8'h0, line}, 9'h0);
    send(8'($random(seed)));
    drain();
    wr(4'h2, 8'h00);
    #1 pol = 1'b0;
    listen = 1'b0;
    send(8'ha5);
    repeat (10) @(posedge core_clk);
    wr(4'h0, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 check({8'h0, line}, 9'h1);
    rd(4'h0, 8'h00);
    repeat (60) @(posedge core_clk);
    exp_q.delete();
    listen = 1'b1;
    wr(4'h0, 8'h01);
    rd(4'h6, 8'h01);
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== tb/serial_rx_model.sv
// far-end receiver model that decodes frames from the line
`timescale 1ns/1ns
`default_nettype none
module serial_rx_model (
  // clock and line
  input wire logic core_clk,
  input wire logic line,
  // format
  input wire logic pol,
  input wire logic nine,
  input wire logic [31:0] bit_cycles,
  // decoded character
  output logic got,
  output logic [8:0] word,
  output logic stop_ok,
  output int gap
);
  int cyc = 0;
  int last = 0;
  int i;
  initial
  begin
    got = 1'b0;
    word = '0;
    stop_ok = 1'b0;
    gap = 0;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  // samples mid-bit, so a bit shorter or longer than bit_cycles shifts the data
  always
  begin
    @(posedge core_clk);
    if ((line ^ pol) === 1'b0)
    begin
      gap = cyc - last;
      last = cyc;
      word = '0;
      repeat (bit_cycles / 2) @(posedge core_clk);
      for (i = 0; i < 9; i++)
      begin
        if (i < 8 || nine)
        begin
          repeat (bit_cycles) @(posedge core_clk);
          word[i] = line ^ pol;
        end
      end
      repeat (bit_cycles) @(posedge core_clk);
      stop_ok = line ^ pol;
      got = 1'b1;
      #1 got = 1'b0;
    end
  end
endmodule
`default_nettype wire
